/* rtl/itc_pkg.sv */
// ****************************************************************
// Shared constants for the target and speed configuration block
// ****************************************************************
package itc_pkg;
    // Register byte offsets
    localparam logic [7:0]  ADDR_CONFIG      = 8'h00;
    localparam logic [7:0]  ADDR_TARGET      = 8'h04;
    localparam logic [7:0]  ADDR_OWN         = 8'h08;
    localparam logic [7:0]  ADDR_ENABLE      = 8'h0C;
    localparam logic [7:0]  ADDR_STATUS      = 8'h10;
    localparam logic [7:0]  ADDR_RAWIRQ      = 8'h14;
    // Configuration word fields
    localparam int          CFG_MASTER_BIT   = 0;
    localparam int          CFG_SPEED_LSB    = 1;
    localparam int          CFG_RESP_DIS_BIT = 6;
    localparam logic [1:0]  CFG_SPEED_RST    = 2'h2;
    localparam logic        CFG_MASTER_RST   = 1'b1;
    localparam logic        CFG_RESP_DIS_RST = 1'b1;
    // Target address fields
    localparam int          TAR_WIDTH        = 12;
    localparam int          TAR_SPECIAL_BIT  = 11;
    localparam int          TAR_GCSTART_BIT  = 10;
    localparam logic [11:0] TAR_RST          = 12'h055;
    localparam logic [9:0]  OWN_RST          = 10'h055;
    // Enable, status and raw event fields
    localparam int          ENA_BIT          = 0;
    localparam int          STAT_TXEMPTY_BIT = 2;
    localparam int          RAW_ABORT_BIT    = 6;
    // Speed classes and build options
    localparam logic [1:0]  SPEED_STD        = 2'h1;
    localparam logic [1:0]  SPEED_FAST       = 2'h2;
    localparam logic [1:0]  SPEED_HIGH       = 2'h3;
    localparam logic [1:0]  MAX_RATE_PARAM   = 2'h3;
    localparam logic        ULTRAFAST_PARAM  = 1'b0;
    // Nominal bus rate ceilings in kbit/s
    localparam logic [11:0] RATE_STD_KBPS    = 12'd100;
    localparam logic [11:0] RATE_FAST_KBPS   = 12'd400;
    localparam logic [11:0] RATE_FPLUS_KBPS  = 12'd1000;
    localparam logic [11:0] RATE_HIGH_KBPS   = 12'd3400;
    // Spike filter lengths in clock cycles
    localparam logic [7:0]  SPK_LEN_FS       = 8'h07;
    localparam logic [7:0]  SPK_LEN_HS       = 8'h01;
    localparam logic [7:0]  SPK_LEN_UF       = 8'h01;
    // Master addressing mode
    typedef enum logic [1:0] {MODE_NORMAL, MODE_GCALL, MODE_STARTB} itc_mode_type;
endpackage

/* rtl/itc_cfg_if.sv */
`timescale 1ns/1ps
// ****************************************************************
// Carrier between the bus front end and the two setting holders
// ****************************************************************
interface itc_cfg_if;
    logic        cfg_we;        // Config word write strobe
    logic [1:0]  speed_wr;      // Speed value as written
    logic [1:0]  speed_q;       // Stored, legal speed
    logic [7:0]  spike_len;     // Filter length for the class
    logic [11:0] rate_kbps;     // Rate ceiling of the class
    logic        tar_we;        // Target write strobe, already gated
    logic [11:0] tar_wr;        // Target value as written
    logic [11:0] tar_q;         // Stored target word
    logic [9:0]  own_addr;      // Own slave address
    logic        master_en;     // Master operation on
    logic        resp_dis;      // Slave side off
    logic        cmd_valid;     // Command offered
    logic        cmd_read;      // Command is a read
    logic        cmd_ok;        // Command accepted, pulse
    logic        cmd_abort;     // Command aborted, pulse
    logic        loop;          // Target equals own address
    logic [1:0]  mode;          // Addressing mode
    modport top (output cfg_we, speed_wr, tar_we, tar_wr, own_addr, master_en, resp_dis, cmd_valid, cmd_read,
                 input speed_q, spike_len, rate_kbps, tar_q, cmd_ok, cmd_abort, loop, mode);
    modport spd (input cfg_we, speed_wr, output speed_q, spike_len, rate_kbps);
    modport tgt (input tar_we, tar_wr, own_addr, master_en, resp_dis, cmd_valid, cmd_read,
                 output tar_q, cmd_ok, cmd_abort, loop, mode);
endinterface

/* rtl/itc_speed_ctl.sv */
`timescale 1ns/1ps
// ****************************************************************
// Speed class holder with illegal value protection
// ****************************************************************
module itc_speed_ctl
    import itc_pkg::*;
(
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Settings carrier
    itc_cfg_if.spd    cfg
);
    logic [1:0]  speed_d;     // Next speed
    logic [7:0]  spike_d;     // Next filter length
    logic [11:0] rate_d;      // Next rate ceiling

    // Replace an out of range speed by the top class
    function automatic logic [1:0] legal_speed(input logic [1:0] v);
        if (v < SPEED_STD || v > MAX_RATE_PARAM) begin
            return MAX_RATE_PARAM;
        end
        return v;
    endfunction

    // Next values from a write or the stored class
    always_comb begin
        speed_d = cfg.speed_q;
        if (cfg.cfg_we) begin
            speed_d = legal_speed(cfg.speed_wr);
        end
        // Filter follows the class in slave mode too
        if (ULTRAFAST_PARAM) begin
            spike_d = SPK_LEN_UF;
        end else if (speed_d == SPEED_HIGH) begin
            spike_d = SPK_LEN_HS;
        end else begin
            spike_d = SPK_LEN_FS;
        end
        // Rate ceiling per class
        case (speed_d)
            SPEED_STD:  rate_d = RATE_STD_KBPS;
            SPEED_FAST: rate_d = RATE_FPLUS_KBPS;
            SPEED_HIGH: rate_d = RATE_HIGH_KBPS;
            default:    rate_d = RATE_FAST_KBPS;
        endcase
    end

    // Registers only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg.speed_q   <= CFG_SPEED_RST;
            cfg.spike_len <= SPK_LEN_FS;
            cfg.rate_kbps <= RATE_FPLUS_KBPS;
        end else begin
            cfg.speed_q   <= speed_d;
            cfg.spike_len <= spike_d;
            cfg.rate_kbps <= rate_d;
        end
    end
endmodule

/* rtl/itc_target_ctl.sv */
`timescale 1ns/1ps
// ****************************************************************
// Target address holder and master command screening
// ****************************************************************
module itc_target_ctl
    import itc_pkg::*;
(
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Settings carrier
    itc_cfg_if.tgt    cfg
);
    logic [11:0]  tar_d;      // Next target word
    logic         ok_d;       // Next accept pulse
    logic         abort_d;    // Next abort pulse
    logic         loop_d;     // Next loopback flag
    itc_mode_type mode_d;     // Next mode

    // Decode the addressing mode from a target word
    function automatic itc_mode_type mode_of(input logic [11:0] t);
        if (!t[TAR_SPECIAL_BIT]) begin
            return MODE_NORMAL;
        end else if (t[TAR_GCSTART_BIT]) begin
            return MODE_STARTB;
        end
        return MODE_GCALL;
    endfunction

    // Next values
    always_comb begin
        tar_d   = cfg.tar_q;
        ok_d    = 1'b0;
        abort_d = 1'b0;
        if (cfg.tar_we) begin
            tar_d = cfg.tar_wr;
        end
        // Mode stays general call until the special bit drops or bit 10 rises
        mode_d = mode_of(tar_d);
        // Shared buffers make only one way loopback workable
        loop_d = !cfg.resp_dis && (tar_d[9:0] == cfg.own_addr);
        if (cfg.cmd_valid && cfg.master_en) begin
            if (mode_of(cfg.tar_q) == MODE_GCALL && cfg.cmd_read) begin
                abort_d = 1'b1;
            end else if (cfg.loop && !cfg.cmd_read) begin
                abort_d = 1'b1;
            end else begin
                ok_d = 1'b1;
            end
        end
    end

    // Registers only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg.tar_q     <= TAR_RST;
            cfg.cmd_ok    <= 1'b0;
            cfg.cmd_abort <= 1'b0;
            cfg.loop      <= 1'b0;
            cfg.mode      <= MODE_NORMAL;
        end else begin
            cfg.tar_q     <= tar_d;
            cfg.cmd_ok    <= ok_d;
            cfg.cmd_abort <= abort_d;
            cfg.loop      <= loop_d;
            cfg.mode      <= mode_d;
        end
    end
endmodule

/* rtl/itc_top.sv */
`timescale 1ns/1ps
// ****************************************************************
// Bus front end and outputs
// ****************************************************************
module itc_top
    import itc_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Command path from the transmit queue
    input  wire logic        cmd_valid,
    input  wire logic        cmd_read,
    input  wire logic        tx_fifo_empty,
    output logic             cmd_accept,
    output logic             cmd_abort,
    // Settings towards the bus engine
    output logic             master_enable,
    output logic             responder_disable,
    output logic             block_enable,
    output logic [1:0]       speed_class,
    output logic [7:0]       spike_len,
    output logic [11:0]      rate_kbps,
    output logic [9:0]       target_address,
    output logic             send_general_call,
    output logic             send_start_byte,
    output logic             loopback_simplex,
    output logic             transmit_abort_flag
);
    // ****************************************************************
    // Local state
    // ****************************************************************
    itc_cfg_if   cfg ();            // Carrier to the two holders
    logic        dp_wr_q;           // Data phase of a write pending
    logic        dp_wr_d;
    logic [7:0]  dp_addr_q;         // Address captured in address phase
    logic [7:0]  dp_addr_d;
    logic [31:0] rdata_q;           // Read data register
    logic [31:0] rdata_d;
    logic        master_q;          // Master enable bit
    logic        master_d;
    logic        resp_dis_q;        // Slave disable bit
    logic        resp_dis_d;
    logic        ena_q;             // Block enable bit
    logic        ena_d;
    logic [9:0]  own_q;             // Own slave address
    logic [9:0]  own_d;
    logic        abort_q;           // Sticky abort event
    logic        abort_d;
    logic        ap_take;           // Address phase accepted
    logic        wr_cfg;            // Config write in data phase
    logic        wr_tar;            // Target write in data phase
    logic        wr_own;            // Own address write
    logic        wr_ena;            // Enable write
    logic        wr_raw;            // Raw event clear write

    // ****************************************************************
    // Register read mux
    // ****************************************************************
    // Unmapped offsets and reserved bits read as zero
    function automatic logic [31:0] read_word(input logic [7:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            ADDR_CONFIG: begin
                w[CFG_MASTER_BIT]                 = master_q;
                w[CFG_SPEED_LSB +: 2]             = cfg.speed_q;
                w[CFG_RESP_DIS_BIT]               = resp_dis_q;
            end
            ADDR_TARGET: begin
                w[TAR_WIDTH-1:0]                  = cfg.tar_q;
            end
            ADDR_OWN: begin
                w[9:0]                            = own_q;
            end
            ADDR_ENABLE: begin
                w[ENA_BIT]                        = ena_q;
            end
            ADDR_STATUS: begin
                w[STAT_TXEMPTY_BIT]               = tx_fifo_empty;
                w[4:3]                            = cfg.mode;
                w[5]                              = cfg.loop;
            end
            ADDR_RAWIRQ: begin
                w[RAW_ABORT_BIT]                  = abort_q;
            end
            default: begin
                w = 32'h0000_0000;
            end
        endcase
        return w;
    endfunction

    // ****************************************************************
    // Bus phase tracking
    // ****************************************************************
    // A transfer is taken when selected, non-idle and the bus is ready
    assign ap_take = hsel && htrans[1] && hready;

    // Next phase state; zero wait states, so read data is prepared early
    always_comb begin
        dp_wr_d   = 1'b0;
        dp_addr_d = dp_addr_q;
        rdata_d   = rdata_q;
        if (ap_take) begin
            dp_addr_d = haddr[7:0];
            if (hwrite) begin
                dp_wr_d = 1'b1;
            end else begin
                // Sampled here so hrdata stands from a flop in the data phase
                rdata_d = read_word(haddr[7:0]);
            end
        end
    end

    // Phase registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_q   <= 1'b0;
            dp_addr_q <= 8'h00;
            rdata_q   <= 32'h0000_0000;
        end else begin
            dp_wr_q   <= dp_wr_d;
            dp_addr_q <= dp_addr_d;
            rdata_q   <= rdata_d;
        end
    end

    // ****************************************************************
    // Write decode
    // ****************************************************************
    // Addresses above the low byte alias; the decode only looks at 8 bits
    assign wr_cfg = dp_wr_q && (dp_addr_q == ADDR_CONFIG);
    assign wr_tar = dp_wr_q && (dp_addr_q == ADDR_TARGET) && !ena_q;
    assign wr_own = dp_wr_q && (dp_addr_q == ADDR_OWN) && !ena_q;
    assign wr_ena = dp_wr_q && (dp_addr_q == ADDR_ENABLE);
    assign wr_raw = dp_wr_q && (dp_addr_q == ADDR_RAWIRQ);

    // ****************************************************************
    // Control bits
    // ****************************************************************
    // Next values of the bits held here
    always_comb begin
        master_d   = master_q;
        resp_dis_d = resp_dis_q;
        ena_d      = ena_q;
        own_d      = own_q;
        abort_d    = abort_q;
        if (wr_cfg) begin
            master_d   = hwdata[CFG_MASTER_BIT];
            resp_dis_d = hwdata[CFG_RESP_DIS_BIT];
        end
        if (wr_ena) begin
            ena_d = hwdata[ENA_BIT];
        end
        if (wr_own) begin
            own_d = hwdata[9:0];
        end
        // Write one to clear; a new abort in the same cycle still wins
        if (wr_raw && hwdata[RAW_ABORT_BIT]) begin
            abort_d = 1'b0;
        end
        if (cfg.cmd_abort) begin
            abort_d = 1'b1;
        end
    end

    // Control registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            master_q   <= CFG_MASTER_RST;
            resp_dis_q <= CFG_RESP_DIS_RST;
            ena_q      <= 1'b0;
            own_q      <= OWN_RST;
            abort_q    <= 1'b0;
        end else begin
            master_q   <= master_d;
            resp_dis_q <= resp_dis_d;
            ena_q      <= ena_d;
            own_q      <= own_d;
            abort_q    <= abort_d;
        end
    end

    // ****************************************************************
    // Carrier drive and holders
    // ****************************************************************
    assign cfg.cfg_we    = wr_cfg;
    assign cfg.speed_wr  = hwdata[CFG_SPEED_LSB +: 2];
    assign cfg.tar_we    = wr_tar;
    assign cfg.tar_wr    = hwdata[TAR_WIDTH-1:0];
    assign cfg.own_addr  = own_q;
    // Commands only flow while the master is on and the block is enabled
    assign cfg.master_en = master_q && ena_q;
    assign cfg.resp_dis  = resp_dis_q;
    assign cfg.cmd_valid = cmd_valid;
    assign cfg.cmd_read  = cmd_read;

    // Speed class holder
    itc_speed_ctl u_speed (
        .hclk    (hclk),
        .hresetn (hresetn),
        .cfg     (cfg)
    );

    // Target holder and command screen
    itc_target_ctl u_target (
        .hclk    (hclk),
        .hresetn (hresetn),
        .cfg     (cfg)
    );

    // ****************************************************************
    // Outputs from flops, mode decodes of a flop, and constant bus answers
    // ****************************************************************
    assign hreadyout           = 1'b1;
    assign hresp               = 1'b0;
    assign hrdata              = rdata_q;
    assign cmd_accept          = cfg.cmd_ok;
    assign cmd_abort           = cfg.cmd_abort;
    assign master_enable       = master_q;
    assign responder_disable   = resp_dis_q;
    assign block_enable        = ena_q;
    assign speed_class         = cfg.speed_q;
    assign spike_len           = cfg.spike_len;
    assign rate_kbps           = cfg.rate_kbps;
    // Address ignored by the engine during a general call
    assign target_address      = cfg.tar_q[9:0];
    assign send_general_call   = (cfg.mode == MODE_GCALL);
    assign send_start_byte     = (cfg.mode == MODE_STARTB);
    assign loopback_simplex    = cfg.loop;
    assign transmit_abort_flag = abort_q;
endmodule

/* bench/itc_top_monitor.sv */
`timescale 1ns/1ps
// ****************************************************************
// Port checker for the target and speed block
// ****************************************************************
module itc_top_monitor
    import itc_pkg::*;
(
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Command path
    input wire logic        cmd_valid,
    input wire logic        cmd_read,
    input wire logic        cmd_accept,
    input wire logic        cmd_abort,
    // Settings
    input wire logic        master_enable,
    input wire logic        block_enable,
    input wire logic [1:0]  speed_class,
    input wire logic [7:0]  spike_len,
    input wire logic [11:0] rate_kbps,
    input wire logic [9:0]  target_address,
    input wire logic        send_general_call,
    input wire logic        send_start_byte,
    input wire logic        loopback_simplex,
    input wire logic        transmit_abort_flag
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Command taken and its single answer
    sequence s_take; cmd_valid && master_enable && block_enable; endsequence
    sequence s_answer; cmd_accept ^ cmd_abort; endsequence
    property p_speed_legal; speed_class != 2'h0; endproperty
    property p_rate; rate_kbps == (speed_class == 2'h1 ? 12'd100 : speed_class == 2'h2 ? 12'd1000 : 12'd3400);
    endproperty
    property p_spike; spike_len == (speed_class == 2'h3 ? 8'h01 : 8'h07); endproperty
    property p_answer; s_take |=> s_answer; endproperty
    property p_idle; !(cmd_valid && master_enable && block_enable) |=> !cmd_accept && !cmd_abort; endproperty
    property p_gc_read; s_take ##0 (cmd_read && send_general_call) |=> cmd_abort ##1 transmit_abort_flag; endproperty
    property p_loop; s_take ##0 (!cmd_read && loopback_simplex) |=> cmd_abort; endproperty
    property p_norm; s_take ##0 (!send_general_call && !loopback_simplex) |=> cmd_accept; endproperty
    // Stable enable over three edges freezes the target
    property p_tar_hold; block_enable && $past(block_enable) && $past(block_enable, 2) |-> $stable(target_address);
    endproperty
    property p_modes; !(send_general_call && send_start_byte); endproperty
    a_speed_legal: assert property (p_speed_legal) else $error("speed class zero");
    a_rate: assert property (p_rate) else $error("rate does not match class");
    a_spike: assert property (p_spike) else $error("spike length does not match class");
    a_answer: assert property (p_answer) else $error("taken command without one answer");
    a_idle: assert property (p_idle) else $error("answer without taken command");
    a_gc_read: assert property (p_gc_read) else $error("read in general call not aborted");
    a_loop: assert property (p_loop) else $error("write in loopback not aborted");
    a_norm: assert property (p_norm) else $error("normal command not accepted");
    a_tar_hold: assert property (p_tar_hold) else $error("target changed while enabled");
    a_modes: assert property (p_modes) else $error("two special modes at once");
endmodule

/* bench/itc_cmd_src.sv */
`timescale 1ns/1ps
// ****************************************************************
// Command source standing in for the transmit queue
// ****************************************************************
module itc_cmd_src (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Requests from the bench
    input wire logic req,
    input wire logic req_read,
    // Command path into the block
    output logic     cmd_valid,
    output logic     cmd_read,
    output logic     tx_fifo_empty
);
    // One command per request; idle direction toggles so a stale value never looks real
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_valid <= 1'b0;
            cmd_read <= 1'b0;
            tx_fifo_empty <= 1'b1;
        end else begin
            cmd_valid <= req;
            cmd_read <= req ? req_read : ~cmd_read;
            tx_fifo_empty <= ~req;
        end
    end
endmodule

/* bench/i2c_master_target_config_bench.sv */
`timescale 1ns/1ps
// ****************************************************************
// Bench for the target and speed block
// ****************************************************************
module i2c_master_target_config_bench;
    import itc_pkg::*;
    // Bus side
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, r;
    // Command side and settings
    logic        req = 1'b0, req_read = 1'b0, cmd_valid, cmd_read, tx_fifo_empty, cmd_accept, cmd_abort;
    logic        master_enable, responder_disable, block_enable, send_general_call, send_start_byte;
    logic        loopback_simplex, transmit_abort_flag;
    logic [1:0]  speed_class;
    logic [7:0]  spike_len;
    logic [11:0] rate_kbps;
    logic [9:0]  target_address;
    // Counters and model state
    integer      miscompares = 0, total_checks = 0, cycles = 0, seed = 55, v, m_spd, m_tar;
    assign hready = hreadyout;
    always #50 hclk = ~hclk;
    itc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .cmd_valid(cmd_valid), .cmd_read(cmd_read), .tx_fifo_empty(tx_fifo_empty), .cmd_accept(cmd_accept),
        .cmd_abort(cmd_abort), .master_enable(master_enable), .responder_disable(responder_disable),
        .block_enable(block_enable), .speed_class(speed_class), .spike_len(spike_len), .rate_kbps(rate_kbps),
        .target_address(target_address), .send_general_call(send_general_call), .send_start_byte(send_start_byte),
        .loopback_simplex(loopback_simplex), .transmit_abort_flag(transmit_abort_flag));
    itc_cmd_src src (.hclk(hclk), .hresetn(hresetn), .req(req), .req_read(req_read), .cmd_valid(cmd_valid),
        .cmd_read(cmd_read), .tx_fifo_empty(tx_fifo_empty));
    // Single word transfer, held until ready is seen
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // One command, then the answer pulse pair in its only cycle
    task automatic cmd(input logic rdc, input logic acc, input logic abt);
        @(posedge hclk);
        req <= 1'b1;
        req_read <= rdc;
        @(posedge hclk);
        req <= 1'b0;
        @(posedge hclk);
        #1;
        chk({30'h0, cmd_accept, cmd_abort}, {30'h0, acc, abt});
    endtask
    task end_sim;
        if (miscompares == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_sim;
        end
    end
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk(ADDR_CONFIG, 32'h45);
        rdchk(ADDR_TARGET, 32'h55);
        rdchk(ADDR_STATUS, 32'h4);
        chk({hresp, hreadyout, master_enable, responder_disable, block_enable}, 32'hE);
        // Every speed code, zero being illegal
        for (v = 0; v < 4; v++) begin
            bus(1'b1, ADDR_CONFIG, 32'h41 | (v << 1));
            m_spd = (v == 0) ? 3 : v;
            rdchk(ADDR_CONFIG, 32'h41 | (m_spd << 1));
            chk(speed_class, m_spd);
            chk(rate_kbps, m_spd == 1 ? 100 : m_spd == 2 ? 1000 : 3400);
            chk(spike_len, m_spd == 3 ? 1 : 7);
        end
        // Random normal targets, reserved bits set, locked while enabled
        repeat (3) begin
            r = $random(seed);
            m_tar = r & 32'h3FF;
            bus(1'b1, ADDR_TARGET, r & 32'hFFFFF3FF);
            rdchk(ADDR_TARGET, m_tar);
            chk(target_address, m_tar);
            bus(1'b1, ADDR_ENABLE, 32'h1);
            cmd(1'b1, 1'b1, 1'b0);
            bus(1'b1, ADDR_TARGET, ~r);
            rdchk(ADDR_TARGET, m_tar);
            bus(1'b1, ADDR_ENABLE, 32'h0);
        end
        // General call: read aborts, write passes, mode holds
        bus(1'b1, ADDR_TARGET, 32'h800 | m_tar);
        bus(1'b1, ADDR_ENABLE, 32'h1);
        rdchk(ADDR_STATUS, 32'hC);
        cmd(1'b1, 1'b0, 1'b1);
        cmd(1'b0, 1'b1, 1'b0);
        rdchk(ADDR_RAWIRQ, 32'h40);
        bus(1'b1, ADDR_RAWIRQ, 32'h40);
        rdchk(ADDR_RAWIRQ, 32'h0);
        chk(send_general_call, 1);
        bus(1'b1, ADDR_ENABLE, 32'h0);
        // Start byte from one write, then back to normal
        bus(1'b1, ADDR_TARGET, 32'hC00 | m_tar);
        rdchk(ADDR_STATUS, 32'h14);
        chk({send_general_call, send_start_byte}, 2'b01);
        bus(1'b1, ADDR_TARGET, m_tar);
        rdchk(ADDR_STATUS, 32'h4);
        // Master off: commands go unanswered
        bus(1'b1, ADDR_CONFIG, 32'h44);
        bus(1'b1, ADDR_ENABLE, 32'h1);
        cmd(1'b0, 1'b0, 1'b0);
        bus(1'b1, ADDR_ENABLE, 32'h0);
        // Responder on and target equal to own address
        bus(1'b1, ADDR_CONFIG, 32'h05);
        bus(1'b1, ADDR_TARGET, 32'h55);
        bus(1'b1, ADDR_ENABLE, 32'h1);
        rdchk(ADDR_STATUS, 32'h24);
        chk({responder_disable, master_enable, block_enable}, 32'h3);
        cmd(1'b0, 1'b0, 1'b1);
        cmd(1'b1, 1'b1, 1'b0);
        // Unmapped place reads zero
        rdchk(8'h20, 32'h0);
        end_sim;
    end
endmodule
bind itc_top itc_top_monitor mon (.hclk(hclk), .hresetn(hresetn), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
    .cmd_accept(cmd_accept), .cmd_abort(cmd_abort), .master_enable(master_enable), .block_enable(block_enable),
    .speed_class(speed_class), .spike_len(spike_len), .rate_kbps(rate_kbps), .target_address(target_address),
    .send_general_call(send_general_call), .send_start_byte(send_start_byte),
    .loopback_simplex(loopback_simplex), .transmit_abort_flag(transmit_abort_flag));
